/* verilog/qus_top.sv */
// Top: channel decode, per-channel registers and ready/interrupt flags
// What this block does
// - Four-select mode: one low select picks its channel; all high deselects.
// - Four-select mode, all four selects low: a write lands in every channel's register.
// - Single-select mode: select low, two address bits pick channel A to D.
// - Extra address bits are used only in single-select mode.
// - Strap high gives four-select mode, strap low single-select mode.
// - Each channel owns a full independent register set.
// - FIFO off: transmit interrupt part low with byte held, high when empty.
// - FIFO on: transmit interrupt part low above trigger, high below or empty.
// - FIFO off: receive interrupt part high with one byte held, else low.
// - FIFO on: receive interrupt part high above trigger, low below.
// - No DMA master; block bit is FIFO control bit 3, ready outputs only.
// - Block bit clear or FIFO off: single-character ready; set with FIFO on: receive-ready at trigger, transmit-ready until full.
// - Receive-ready follows FIFO off, FIFO and block mode behaviour.
// - Transmit-ready follows FIFO off, FIFO and block mode behaviour.
// - Line status bit 5 means room to send, bit 6 transmitter empty.
// - Host cycles need no oscillator; oscillator feeds baud generators only.
// - External clock on oscillator input drives all four baud generators.
// - Baud generator divides by 16-bit divisor, 1 to 65535, for 16x clock.
`timescale 1ns/1ps
module qus_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic bus_type_strap,
  input wire logic port_a_select_n,
  input wire logic port_b_select_n,
  input wire logic port_c_select_n,
  input wire logic port_d_select_n,
  input wire logic [1:0] channel_addr,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [7:0] rd_data,
  output logic data_oe_n,
  input wire logic oscillator_input,
  input wire logic [3:0] tx_level_in,
  input wire logic [3:0] tx_shift_busy,
  input wire logic [3:0] rx_level_in,
  input wire logic [3:0] rx_timeout,
  output logic [3:0] sample_tick,
  output logic [3:0] int_out,
  output logic [3:0] transmit_ready_n,
  output logic [3:0] receive_ready_n
);
  localparam int NCH = qus_pkg::NUM_CH;

  // Four-bit level fields carry 0..15; a level input of all ones plus busy means full
  function automatic logic [4:0] lvl(input logic [3:0] v);
    lvl = {1'b0, v};
  endfunction : lvl

  function automatic logic [4:0] rx_trig(input logic [1:0] code);
    unique case (code)
      2'b00: rx_trig = qus_pkg::RX_TRIG_L0;
      2'b01: rx_trig = qus_pkg::RX_TRIG_L1;
      2'b10: rx_trig = qus_pkg::RX_TRIG_L2;
      2'b11: rx_trig = qus_pkg::RX_TRIG_L3;
    endcase
  endfunction : rx_trig

  // Strap and oscillator are outside the clock domain: three flops each
  logic [2:0] strap_sync_reg;
  logic [2:0] osc_sync_reg;
  qus_pkg::qus_mode_t mode_reg;
  logic osc_tick;
  logic osc_tick_prev_reg;

  // Strap stages start at the default mode's level: no false mode change after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_sync_reg <= {3{qus_pkg::STRAP_FOUR_SEL}};
      osc_sync_reg <= 3'h0;
    end else begin
      strap_sync_reg <= {strap_sync_reg[1:0], bus_type_strap};
      osc_sync_reg <= {osc_sync_reg[1:0], oscillator_input};
    end
  end

  // Mode follows the strap only once the last two stages agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= qus_pkg::QUS_MODE_FOUR;
    end else if (strap_sync_reg[1] == strap_sync_reg[2]) begin
      if (strap_sync_reg[2] == qus_pkg::STRAP_FOUR_SEL) begin
        mode_reg <= qus_pkg::QUS_MODE_FOUR;
      end else begin
        mode_reg <= qus_pkg::QUS_MODE_SINGLE;
      end
    end
  end

  // Rising edge of the oscillator input, once the last two stages agree
  assign osc_tick = osc_sync_reg[1] & osc_sync_reg[2] & ~osc_tick_prev_reg;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_tick_prev_reg <= 1'b0;
    end else if (osc_sync_reg[1] == osc_sync_reg[2]) begin
      osc_tick_prev_reg <= osc_sync_reg[2];
    end
  end

  // Channel decode
  // Four-select mode: two or three selects low match no channel; only all low broadcasts
  logic [3:0] sel_vec;
  logic [3:0] sel_n;
  logic broadcast;
  logic any_sel;
  always_comb begin
    sel_n = {port_d_select_n, port_c_select_n, port_b_select_n, port_a_select_n};
    sel_vec = 4'h0;
    broadcast = 1'b0;
    if (mode_reg == qus_pkg::QUS_MODE_FOUR) begin
      unique case (sel_n)
        4'hE: sel_vec = 4'h1;
        4'hD: sel_vec = 4'h2;
        4'hB: sel_vec = 4'h4;
        4'h7: sel_vec = 4'h8;
        4'h0: begin
          sel_vec = 4'hF;
          broadcast = 1'b1;
        end
        default: sel_vec = 4'h0;
      endcase
    end else if (!port_a_select_n) begin
      sel_vec = 4'h1 << channel_addr;
    end
  end
  assign any_sel = |sel_vec;

  logic [3:0] wr_hit;
  logic rd_hit;
  assign wr_hit = (wr_strobe && any_sel) ? sel_vec : 4'h0;
  // Broadcast reads are a host error and are refused
  assign rd_hit = rd_strobe && any_sel && !broadcast;

  // Per-channel register sets
  logic [7:0] int_en_reg [NCH];
  logic [7:0] fifo_ctl_reg [NCH];
  logic [7:0] line_ctl_reg [NCH];
  logic [7:0] modem_ctl_reg [NCH];
  logic [7:0] scratch_reg [NCH];
  logic [7:0] tx_hold_reg [NCH];
  logic [15:0] divisor_reg [NCH];
  logic [3:0] rx_block_reg;
  logic [7:0] rd_mux [NCH];

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic fifo_on;
      logic block_on;
      logic dlab;
      logic [4:0] tx_lvl;
      logic [4:0] rx_lvl;
      logic tx_empty;
      logic tx_full;
      logic rx_has;
      logic [4:0] rx_tl;
      logic tx_part;
      logic rx_part;
      logic tx_irq;
      logic rx_irq;

      assign fifo_on = fifo_ctl_reg[g][qus_pkg::FC_ENABLE_BIT];
      assign block_on = fifo_ctl_reg[g][qus_pkg::FC_BLOCK_BIT];
      assign dlab = line_ctl_reg[g][qus_pkg::LC_DLAB_BIT];
      // Levels are shared by all channels; busy and timeout are per channel
      assign tx_lvl = lvl(tx_level_in);
      assign rx_lvl = lvl(rx_level_in);
      assign tx_empty = (tx_lvl == 5'h00);
      assign tx_full = (tx_lvl == qus_pkg::LVL_FULL) && tx_shift_busy[g];
      assign rx_has = (rx_lvl != 5'h00);
      assign rx_tl = rx_trig(fifo_ctl_reg[g][qus_pkg::FC_TRIG_LSB +: 2]);
      assign tx_irq = tx_part & int_en_reg[g][qus_pkg::IE_TX_BIT];
      assign rx_irq = rx_part & int_en_reg[g][qus_pkg::IE_RX_BIT];

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          int_en_reg[g] <= qus_pkg::RST_BYTE;
          fifo_ctl_reg[g] <= qus_pkg::RST_BYTE;
          line_ctl_reg[g] <= qus_pkg::RST_BYTE;
          modem_ctl_reg[g] <= qus_pkg::RST_BYTE;
          scratch_reg[g] <= qus_pkg::RST_BYTE;
          tx_hold_reg[g] <= qus_pkg::RST_BYTE;
          divisor_reg[g] <= qus_pkg::RST_DIV;
        end else if (wr_hit[g]) begin
          unique case (reg_addr)
            qus_pkg::OFS_HOLD: begin
              if (dlab) begin
                divisor_reg[g][7:0] <= wr_data;
              end else begin
                tx_hold_reg[g] <= wr_data;
              end
            end
            qus_pkg::OFS_INT_EN: begin
              if (dlab) begin
                divisor_reg[g][15:8] <= wr_data;
              end else begin
                int_en_reg[g] <= wr_data;
              end
            end
            qus_pkg::OFS_FIFO_CTL: fifo_ctl_reg[g] <= wr_data;
            qus_pkg::OFS_LINE_CTL: line_ctl_reg[g] <= wr_data;
            qus_pkg::OFS_MODEM_CTL: modem_ctl_reg[g] <= wr_data;
            qus_pkg::OFS_SCRATCH: scratch_reg[g] <= wr_data;
            qus_pkg::OFS_LINE_STAT, qus_pkg::OFS_MODEM_STAT: ;
          endcase
        end
      end

      // Block-mode receive-ready latch: falls at trigger or timeout, rises on empty
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          rx_block_reg[g] <= 1'b1;
        end else if (!rx_has) begin
          rx_block_reg[g] <= 1'b1;
        end else if (rx_lvl >= rx_tl || rx_timeout[g]) begin
          rx_block_reg[g] <= 1'b0;
        end
      end

      // Transmit and receive parts of the interrupt, per FIFO mode
      always_comb begin
        if (!fifo_on) begin
          tx_part = tx_empty;
          rx_part = rx_has;
        end else begin
          tx_part = (tx_lvl <= qus_pkg::TX_TRIG_LVL);
          rx_part = (rx_lvl >= rx_tl);
        end
      end

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          int_out[g] <= 1'b0;
          transmit_ready_n[g] <= 1'b1;
          receive_ready_n[g] <= 1'b1;
        end else begin
          int_out[g] <= tx_irq | rx_irq;
          if (fifo_on && block_on) begin
            transmit_ready_n[g] <= tx_full;
            receive_ready_n[g] <= rx_block_reg[g];
          end else begin
            transmit_ready_n[g] <= !tx_empty;
            receive_ready_n[g] <= !rx_has;
          end
        end
      end

      // Read view of this channel
      // Holding register reads zero: the receive path lies outside this block
      always_comb begin
        unique case (reg_addr)
          qus_pkg::OFS_HOLD: rd_mux[g] = dlab ? divisor_reg[g][7:0] : 8'h00;
          qus_pkg::OFS_INT_EN: rd_mux[g] = dlab ? divisor_reg[g][15:8] : int_en_reg[g];
          qus_pkg::OFS_FIFO_CTL: rd_mux[g] = {fifo_on, fifo_on, 4'h0, ~int_out[g], 1'b0};
          qus_pkg::OFS_LINE_CTL: rd_mux[g] = line_ctl_reg[g];
          qus_pkg::OFS_MODEM_CTL: rd_mux[g] = modem_ctl_reg[g];
          qus_pkg::OFS_LINE_STAT: begin
            rd_mux[g] = 8'h00;
            rd_mux[g][qus_pkg::LS_RX_READY_BIT] = rx_has;
            rd_mux[g][qus_pkg::LS_TX_ROOM_BIT] = !tx_full && (fifo_on || tx_empty);
            rd_mux[g][qus_pkg::LS_TX_EMPTY_BIT] = tx_empty && !tx_shift_busy[g];
          end
          qus_pkg::OFS_MODEM_STAT: rd_mux[g] = 8'h00;
          qus_pkg::OFS_SCRATCH: rd_mux[g] = scratch_reg[g];
        endcase
      end

      // Oscillator feeds only the baud generators
      qus_baud_gen u_baud (
        .clock(clock),
        .rst_n(rst_n),
        .osc_tick(osc_tick),
        .divisor(divisor_reg[g]),
        .sample_tick(sample_tick[g])
      );
    end
  endgenerate

  // Read data one cycle after the read strobe; bus released otherwise
  // Broadcast and deselected reads never turn the data bus around
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= !rd_hit;
      rd_data <= 8'h00;
      if (rd_hit) begin
        for (int i = 0; i < NCH; i++) begin
          if (sel_vec[i]) rd_data <= rd_mux[i];
        end
      end
    end
  end
endmodule : qus_top

/* verilog/qus_pkg.sv */
// Package: constants for the quad UART channel select and ready flag block
package qus_pkg;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int DIV_W = 16;
  localparam int LVL_W = 5;
  localparam int FIFO_DEPTH = 16;
  // Register offsets within one channel
  localparam logic [2:0] OFS_HOLD = 3'h0;
  localparam logic [2:0] OFS_INT_EN = 3'h1;
  localparam logic [2:0] OFS_FIFO_CTL = 3'h2;
  localparam logic [2:0] OFS_LINE_CTL = 3'h3;
  localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
  localparam logic [2:0] OFS_LINE_STAT = 3'h5;
  localparam logic [2:0] OFS_MODEM_STAT = 3'h6;
  localparam logic [2:0] OFS_SCRATCH = 3'h7;
  // Field positions
  localparam int FC_ENABLE_BIT = 0;
  localparam int FC_BLOCK_BIT = 3;
  localparam int FC_TRIG_LSB = 6;
  localparam int LC_DLAB_BIT = 7;
  localparam int LS_RX_READY_BIT = 0;
  localparam int LS_TX_ROOM_BIT = 5;
  localparam int LS_TX_EMPTY_BIT = 6;
  // Reset values and level thresholds
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_DIV = 16'h0001;
  localparam logic [4:0] TX_TRIG_LVL = 5'h08;
  localparam logic [4:0] LVL_FULL = 5'h0F;
  // Receive trigger levels for fifo_control codes 0 to 3
  localparam logic [4:0] RX_TRIG_L0 = 5'h01;
  localparam logic [4:0] RX_TRIG_L1 = 5'h04;
  localparam logic [4:0] RX_TRIG_L2 = 5'h08;
  localparam logic [4:0] RX_TRIG_L3 = 5'h0E;
  // Interrupt enable bits
  localparam int IE_RX_BIT = 0;
  localparam int IE_TX_BIT = 1;
  // Strap decode: high selects the four-select mode
  localparam logic STRAP_FOUR_SEL = 1'b1;
  typedef enum logic [0:0] {
    QUS_MODE_SINGLE = 1'b0,
    QUS_MODE_FOUR = 1'b1
  } qus_mode_t;
endpackage : qus_pkg

/* verilog/qus_baud_gen.sv */
// Baud generator: divides the oscillator enable by a 16-bit divisor
`timescale 1ns/1ps
module qus_baud_gen (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic osc_tick,
  input wire logic [15:0] divisor,
  output logic sample_tick
);
  logic [15:0] count_reg;

  // Divisor of zero is treated as one
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 16'h0000;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= 1'b0;
      if (osc_tick) begin
        if (count_reg + 16'h0001 >= divisor) begin
          count_reg <= 16'h0000;
          sample_tick <= 1'b1;
        end else begin
          count_reg <= count_reg + 16'h0001;
        end
      end
    end
  end
endmodule : qus_baud_gen

/* tb/qus_top_assertions.sv */
// Checker: bus decode, tick and flag timing of the channel select block
`timescale 1ns/1ps
module qus_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic bus_type_strap,
  input wire logic port_a_select_n,
  input wire logic port_b_select_n,
  input wire logic port_c_select_n,
  input wire logic port_d_select_n,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic data_oe_n,
  input wire logic oscillator_input,
  input wire logic [3:0] tx_level_in,
  input wire logic [3:0] tx_shift_busy,
  input wire logic [3:0] rx_level_in,
  input wire logic [3:0] rx_timeout,
  input wire logic [3:0] sample_tick,
  input wire logic [3:0] int_out,
  input wire logic [3:0] transmit_ready_n,
  input wire logic [3:0] receive_ready_n
);
  logic [3:0] sel;
  logic [2:0] strap_age;
  logic [3:0] osc_age;
  assign sel = {port_d_select_n, port_c_select_n, port_b_select_n, port_a_select_n};
  // Ages let the strap synchroniser and oscillator edge detector settle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_age <= 3'h0;
      osc_age <= 4'h0;
    end else begin
      strap_age <= !$stable(bus_type_strap) ? 3'h0 : strap_age + {2'h0, strap_age != 3'h7};
      osc_age <= !$stable(oscillator_input) ? 4'h0 : osc_age + {3'h0, osc_age != 4'hF};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_rd_four;
    rd_strobe && bus_type_strap && strap_age > 3'h4 && $onehot(~sel);
  endsequence
  sequence s_rd_one;
    rd_strobe && !bus_type_strap && strap_age > 3'h4 && !port_a_select_n;
  endsequence
  sequence s_quiet;
    (!wr_strobe && $stable({tx_level_in, tx_shift_busy, rx_level_in, rx_timeout}))[*3];
  endsequence
  a_read_window: assert property (!data_oe_n |-> $past(rd_strobe))
    else $error("data bus driven without a read");
  a_no_sel_read: assert property (rd_strobe && &sel |=> data_oe_n)
    else $error("deselected read drove the bus");
  a_bcast_no_read: assert property (rd_strobe && sel == 4'h0 && bus_type_strap
      && strap_age > 3'h4 |=> data_oe_n)
    else $error("broadcast read drove the bus");
  a_four_sel_read: assert property (s_rd_four |=> !data_oe_n)
    else $error("selected read not answered");
  a_single_read: assert property (s_rd_one |=> !data_oe_n)
    else $error("single-select read not answered");
  a_osc_quiet: assert property (osc_age > 4'h7 |-> sample_tick == 4'h0)
    else $error("sample tick without oscillator");
  a_tick_pulse: assert property (sample_tick[0] |=> !sample_tick[0])
    else $error("sample tick longer than one cycle");
  a_flags_steady: assert property (s_quiet |=> $stable(transmit_ready_n)
      && $stable(receive_ready_n))
    else $error("ready flag moved without cause");
  a_int_steady: assert property (s_quiet |=> $stable(int_out))
    else $error("interrupt moved without cause");
endmodule : qus_chk
bind qus_top qus_chk i_qus_chk (.clock, .rst_n, .bus_type_strap, .port_a_select_n,
  .port_b_select_n, .port_c_select_n, .port_d_select_n, .wr_strobe, .rd_strobe, .data_oe_n,
  .oscillator_input, .tx_level_in, .tx_shift_busy, .rx_level_in, .rx_timeout, .sample_tick,
  .int_out, .transmit_ready_n, .receive_ready_n);

/* tb/qus_cpu_model.sv */
// Host CPU model: one bus cycle per call on the parallel port
`timescale 1ns/1ps
module qus_cpu_model (
  input wire logic clock,
  output logic [3:0] sel_n,
  output logic [1:0] channel_addr,
  output logic [2:0] reg_addr,
  output logic [7:0] wr_data,
  output logic wr_strobe,
  output logic rd_strobe
);
  initial begin
    sel_n = 4'hF;
    channel_addr = 2'h0;
    reg_addr = 3'h0;
    wr_data = 8'h00;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
  end
  task automatic cycle(input logic [3:0] s, input logic [1:0] c, input logic [2:0] a,
      input logic [7:0] d, input logic rd);
    @(posedge clock);
    sel_n <= s;
    channel_addr <= c;
    reg_addr <= a;
    wr_data <= d;
    wr_strobe <= !rd;
    rd_strobe <= rd; // Broadcast read only when a scenario asks
    @(posedge clock);
    wr_strobe <= 1'b0;
    rd_strobe <= 1'b0;
    sel_n <= 4'hF;
    wr_data <= ~d;
  endtask : cycle
endmodule : qus_cpu_model

/* tb/qus_top_bench.sv */
// Bench: drives the channel select block through the host model
`timescale 1ns/1ps
module qus_top_bench;
  localparam logic [2:0] O_SCR = qus_pkg::OFS_SCRATCH;
  localparam logic [2:0] O_FIFO = qus_pkg::OFS_FIFO_CTL;
  localparam logic [2:0] O_IEN = qus_pkg::OFS_INT_EN;
  localparam logic [2:0] O_LCTL = qus_pkg::OFS_LINE_CTL;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic bus_type_strap = 1'b1;
  logic oscillator_input = 1'b0;
  logic osc_run = 1'b0;
  logic [1:0] osc_div = 2'h0;
  logic [3:0] tx_level_in = 4'h0, tx_shift_busy = 4'h0, rx_level_in = 4'h0, rx_timeout = 4'h0;
  logic [3:0] sel_n, sample_tick, int_out, transmit_ready_n, receive_ready_n;
  logic [1:0] channel_addr;
  logic [2:0] reg_addr;
  logic [7:0] wr_data, rd_data, na, nb;
  logic wr_strobe, rd_strobe, data_oe_n;
  logic [15:0] stim [6] = '{16'h0000, 16'h1010, 16'hFF50, 16'hFF10, 16'h0000, 16'h0014};
  logic [15:0] expv [6] = '{16'h0F36, 16'h3C10, 16'hF080, 16'hF000, 16'h0F36, 16'h0836};
  int n_errors = 0;
  int samples_checked = 0;
  always #5 clock = ~clock;
  always @(posedge clock) begin // External baud clock, period 8 cycles
    if (osc_run) begin
      osc_div <= osc_div + 2'h1;
      if (osc_div == 2'h3) oscillator_input <= ~oscillator_input;
    end
  end
  qus_cpu_model i_qus_cpu_model (.clock, .sel_n, .channel_addr, .reg_addr, .wr_data,
    .wr_strobe, .rd_strobe);
  qus_top i_qus_top (.clock, .rst_n, .bus_type_strap, .port_a_select_n(sel_n[0]),
    .port_b_select_n(sel_n[1]), .port_c_select_n(sel_n[2]), .port_d_select_n(sel_n[3]),
    .channel_addr, .reg_addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data, .data_oe_n,
    .oscillator_input, .tx_level_in, .tx_shift_busy, .rx_level_in, .rx_timeout,
    .sample_tick, .int_out, .transmit_ready_n, .receive_ready_n);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] s, input logic [1:0] c, input logic [2:0] a,
      input logic [7:0] d);
    i_qus_cpu_model.cycle(s, c, a, d, 1'b0);
  endtask : wr
  task automatic rd_chk(input logic [3:0] s, input logic [1:0] c, input logic [2:0] a,
      input logic e_oe, input logic [7:0] e_d, input logic [7:0] m);
    i_qus_cpu_model.cycle(s, c, a, 8'h00, 1'b1);
    @(posedge clock);
    check({7'h0, data_oe_n}, {7'h0, e_oe});
    if (!e_oe) check(rd_data & m, e_d);
  endtask : rd_chk
  task automatic t_four;
    for (int i = 0; i < 4; i++) begin
      wr(~(4'h1 << i), 2'(3 - i), O_SCR, 8'h10 + 8'(i));
    end
    for (int i = 0; i < 8; i++) begin
      if (i == 4) wr(4'h0, 2'h0, O_SCR, 8'hA5);
      rd_chk(~(4'h1 << (i % 4)), 2'(i), O_SCR, 1'b0, (i < 4) ? 8'h10 + 8'(i) : 8'hA5,
        8'hFF);
    end
    wr(4'hF, 2'h0, O_SCR, 8'h3C);
    rd_chk(4'hF, 2'h0, O_SCR, 1'b1, 8'h00, 8'h00);
    rd_chk(4'h0, 2'h0, O_SCR, 1'b1, 8'h00, 8'h00);
    rd_chk(4'hE, 2'h0, O_SCR, 1'b0, 8'hA5, 8'hFF);
  endtask : t_four
  task automatic t_single;
    bus_type_strap <= 1'b0;
    repeat (6) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      wr(4'hE, 2'(i), O_SCR, 8'h50 + 8'(i));
    end
    for (int i = 0; i < 4; i++) begin
      rd_chk(4'h0, 2'(i), O_SCR, 1'b0, 8'h50 + 8'(i), 8'hFF);
      rd_chk(4'h1, 2'(i), O_SCR, 1'b1, 8'h00, 8'h00);
    end
  endtask : t_single
  task automatic t_flags;
    wr(4'hE, 2'h0, O_FIFO, 8'h01);
    wr(4'hE, 2'h0, O_IEN, 8'h02);
    wr(4'hE, 2'h1, O_IEN, 8'h02);
    wr(4'hE, 2'h2, O_FIFO, 8'h49);
    wr(4'hE, 2'h3, O_FIFO, 8'h49);
    wr(4'hE, 2'h3, O_IEN, 8'h01);
    for (int i = 0; i < 6; i++) begin
      {tx_level_in, tx_shift_busy, rx_level_in, rx_timeout} <= stim[i];
      repeat (4) @(posedge clock);
      check({4'h0, transmit_ready_n}, {4'h0, expv[i][15:12]});
      check({4'h0, receive_ready_n}, {4'h0, expv[i][11:8]});
      check({4'h0, int_out}, {4'h0, expv[i][7:4]});
      rd_chk(4'hE, 2'h1, qus_pkg::OFS_LINE_STAT, 1'b0, {expv[i][3:0], 4'h0}, 8'h60);
    end
  endtask : t_flags
  task automatic t_baud;
    wr(4'hE, 2'h0, O_LCTL, 8'h80);
    wr(4'hE, 2'h0, 3'h0, 8'h02);
    wr(4'hE, 2'h0, 3'h1, 8'h00);
    wr(4'hE, 2'h0, O_LCTL, 8'h03);
    osc_run <= 1'b1;
    repeat (40) @(posedge clock);
    na = 8'h00;
    nb = 8'h00;
    repeat (160) begin
      @(posedge clock);
      na += {7'h0, sample_tick[0]};
      nb += {7'h0, sample_tick[1]} + {7'h0, sample_tick[2]} + {7'h0, sample_tick[3]};
    end
    check(na, 8'h0A);
    check(nb, 8'h3C);
    osc_run <= 1'b0;
    repeat (20) @(posedge clock);
  endtask : t_baud
  task automatic end_of_test;
    $display("Checks %0d, errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #100us;
    n_errors++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_four();
    t_single();
    t_flags();
    t_baud();
    end_of_test();
  end
endmodule : qus_top_bench
